// file: hw/fpc_pkg.sv
// Package with register indices, field positions and reset values of the fast pulse counter.
package fpc_pkg;
    localparam int ADDR_W = 18;
    // Printed offsets are register indices; byte address is four times the index
    localparam logic [15:0] IDX_T0_CTRL = 16'hfe10;
    localparam logic [15:0] IDX_T0_LCNT = 16'hfe12;
    localparam logic [15:0] IDX_T0_HCNT = 16'hfe13;
    localparam logic [15:0] IDX_T0_LMATCH = 16'hfe14;
    localparam logic [15:0] IDX_T0_HMATCH = 16'hfe15;
    localparam logic [15:0] IDX_T0_CAPL = 16'hfe16;
    localparam logic [15:0] IDX_T0_CAPH = 16'hfe17;
    localparam logic [15:0] IDX_P1_TEST = 16'hfe47;
    localparam logic [15:0] IDX_IRQ01 = 16'hfe5d;
    localparam logic [15:0] IDX_IRQ23 = 16'hfe5e;
    localparam logic [15:0] IDX_INSEL = 16'hfe5f;
    localparam logic [15:0] IDX_FC_CTRL = 16'hfe7d;
    // timer0_control fields
    localparam int T0_HIGH_RUN = 7;
    localparam int T0_LOW_RUN = 6;
    localparam int T0_WIDTH_SEL = 5;
    localparam int T0_EXT_SEL = 4;
    localparam int T0_HIGH_FLAG = 3;
    localparam int T0_HIGH_IE = 2;
    localparam int T0_LOW_FLAG = 1;
    localparam int T0_LOW_IE = 0;
    // fast_counter_control fields
    localparam int FC_ENABLE = 7;
    localparam int FC_CMP_LSB = 4;
    localparam int FC_CARRY = 3;
    // port1_test_control field
    localparam int P1_RT_DISABLE = 2;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_FINE = 3'h0;
    localparam logic RST_BIT = 1'b0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hw/fpc_reg_if.sv
// Interface between the AXI4-Lite slave and the register file of the core.
`timescale 1ns/1ps
interface fpc_reg_if;
    logic wr_en;
    logic [fpc_pkg::ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_ok;
    logic rd_en;
    logic [fpc_pkg::ADDR_W-1:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_ok;
    modport bus (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input wr_ok, rd_data, rd_ok);
    modport regs (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface

// file: hw/fpc_sync.sv
// Two flip-flop synchroniser, one stage pair per bit.
`timescale 1ns/1ps
module fpc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            meta_d[i] = d[i];
            sync_d[i] = meta_q[i];
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= meta_d[i];
                sync_q[i] <= sync_d[i];
            end
        end
    end

    assign q = sync_q;
endmodule

// file: hw/fpc_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into single-cycle register strobes.
`timescale 1ns/1ps
module fpc_axil_slave (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic [fpc_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read
    input wire logic [fpc_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    fpc_reg_if.bus regs
);
    logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic lane_q, lane_d;
    logic [fpc_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic fire;

    // A new write waits until the previous response has been taken
    assign awready = !aw_got_q && !bvalid_q;
    assign wready = !w_got_q && !bvalid_q;
    assign arready = !rvalid_q;
    assign fire = aw_got_q && w_got_q;
    assign regs.wr_en = fire && lane_q;
    assign regs.wr_addr = addr_q;
    assign regs.wr_data = data_q;
    assign regs.rd_en = arvalid && arready;
    assign regs.rd_addr = araddr;

    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        addr_d = addr_q;
        data_d = data_q;
        lane_d = lane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (awvalid && awready) begin
            aw_got_d = 1'b1;
            addr_d = awaddr;
        end
        if (wvalid && wready) begin
            w_got_d = 1'b1;
            data_d = wdata[7:0];
            lane_d = wstrb[0];
        end
        if (fire) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = regs.wr_ok ? fpc_pkg::RESP_OKAY : fpc_pkg::RESP_SLVERR;
        end else if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (regs.rd_en) begin
            rvalid_d = 1'b1;
            rdata_d = {24'h000000, regs.rd_data};
            rresp_d = regs.rd_ok ? fpc_pkg::RESP_OKAY : fpc_pkg::RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            addr_q <= '0;
            data_q <= 8'h00;
            lane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= fpc_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= fpc_pkg::RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            addr_q <= addr_d;
            data_q <= data_d;
            lane_q <= lane_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;
endmodule

// file: hw/fpc_top.sv
// Fast pulse counter joined to timer 0, with capture, match and realtime output.
`timescale 1ns/1ps
module fpc_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [fpc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [fpc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic fast_count_input,
    input wire logic capture_low_pin,
    input wire logic capture_high_pin,
    output logic realtime_output_pin,
    // Neighbouring chip logic
    input wire logic prescale_tick,
    input wire logic port_latch_bit,
    output logic low_irq_req,
    output logic high_irq_req
);
    fpc_reg_if rif ();

    fpc_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .regs(rif.bus)
    );

    // Pin inputs pass two flip-flops; edges are taken on the synchronised copies only
    logic [2:0] pins_s;
    logic [2:0] pins_prev_q;
    logic [2:0] pins_rise;
    fpc_sync #(.W(3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({capture_high_pin, capture_low_pin, fast_count_input}),
        .q(pins_s)
    );
    assign pins_rise = pins_s & ~pins_prev_q;

    // Address decode
    function automatic logic hit_idx(input logic [fpc_pkg::ADDR_W-1:0] a, input logic [15:0] idx);
        hit_idx = (a == {idx, 2'b00});
    endfunction

    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] low_q, low_d, high_q, high_d;
    logic [7:0] lmatch_q, lmatch_d, hmatch_q, hmatch_d;
    logic [7:0] capl_q, capl_d, caph_q, caph_d;
    logic [7:0] irq01_q, irq01_d, irq23_q, irq23_d, insel_q, insel_d;
    logic rt_dis_q, rt_dis_d;
    logic fc_en_q, fc_en_d;
    logic [2:0] cmp_q, cmp_d;
    logic [2:0] fine_q, fine_d;
    logic [2:0] fcap_q, fcap_d;
    logic carry_q, carry_d;
    logic armed_q, armed_d;
    logic frozen_q, frozen_d;

    logic wr_ctrl, wr_fc;
    logic low_run, high_run, wide, ext_sel;
    logic cnt_pulse, fine_inc, fine_ovf, low_inc, high_inc;
    logic [18:0] count19, target19;
    logic [10:0] count11, target11;
    logic fc_hit, low_set, high_set;
    logic normal_low_hit, normal_high_hit;

    assign wr_ctrl = rif.wr_en && hit_idx(rif.wr_addr, fpc_pkg::IDX_T0_CTRL);
    assign wr_fc = rif.wr_en && hit_idx(rif.wr_addr, fpc_pkg::IDX_FC_CTRL);
    assign low_run = ctrl_q[fpc_pkg::T0_LOW_RUN];
    assign high_run = ctrl_q[fpc_pkg::T0_HIGH_RUN];
    assign wide = ctrl_q[fpc_pkg::T0_WIDTH_SEL];
    assign ext_sel = ctrl_q[fpc_pkg::T0_EXT_SEL];
    assign cnt_pulse = pins_rise[0];

    // Fine counter counts pin pulses while enabled and the low byte runs
    assign fine_inc = fc_en_q && low_run && cnt_pulse;
    assign fine_ovf = fine_inc && (fine_q == 3'h7);

    // Combined count and target; (match + 1) * 8 + fine compare is a concatenation
    assign count19 = {high_q, low_q, fine_q};
    assign count11 = {low_q, fine_q};
    assign target19 = {16'({hmatch_q, lmatch_q} + 16'h0001), cmp_q};
    assign target11 = {8'(lmatch_q + 8'h01), cmp_q};
    // Only the first equality after an arming write counts
    assign fc_hit = fc_en_q && armed_q && (wide ? (count19 == target19) : (count11 == target11));

    // Standalone timer matches; the match buffer is taken as the match register itself
    assign normal_low_hit = !fc_en_q && low_run && (wide ? ({high_q, low_q} == {hmatch_q, lmatch_q})
                                                          : (low_q == lmatch_q));
    assign normal_high_hit = (!wide || !fc_en_q) && high_run &&
                             (wide ? normal_low_hit : (high_q == hmatch_q));

    always_comb begin
        low_inc = 1'b0;
        high_inc = 1'b0;
        if (fc_en_q) begin
            low_inc = fine_ovf;
            high_inc = wide ? (fine_ovf && low_q == 8'hff) : (high_run && prescale_tick);
        end else begin
            low_inc = low_run && (ext_sel ? cnt_pulse : prescale_tick);
            high_inc = wide ? (low_inc && low_q == 8'hff) : (high_run && prescale_tick);
        end
    end

    assign low_set = fc_hit || (normal_low_hit && low_inc);
    assign high_set = (fc_hit && wide) || (normal_high_hit && (wide ? low_inc : high_inc));

    // Counters
    always_comb begin
        fine_d = fine_q;
        low_d = low_q;
        high_d = high_q;
        if (!fc_en_q || !low_run) begin
            fine_d = fpc_pkg::RST_FINE;
        end else if (fine_inc) begin
            fine_d = 3'(fine_q + 3'h1);
        end
        if (!low_run) begin
            low_d = fpc_pkg::RST_BYTE;
        end else if (normal_low_hit && low_inc) begin
            low_d = fpc_pkg::RST_BYTE;
        end else if (low_inc) begin
            low_d = 8'(low_q + 8'h01);
        end
        if (!(wide ? low_run : high_run)) begin
            high_d = fpc_pkg::RST_BYTE;
        end else if (normal_high_hit && (wide ? low_inc : high_inc)) begin
            high_d = fpc_pkg::RST_BYTE;
        end else if (high_inc) begin
            high_d = 8'(high_q + 8'h01);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fine_q <= fpc_pkg::RST_FINE;
            low_q <= fpc_pkg::RST_BYTE;
            high_q <= fpc_pkg::RST_BYTE;
            pins_prev_q <= 3'h0;
        end else begin
            fine_q <= fine_d;
            low_q <= low_d;
            high_q <= high_d;
            pins_prev_q <= pins_s;
        end
    end

    // Captures take the post-edge fine count; the carry marks a timer bump still in flight
    always_comb begin
        capl_d = capl_q;
        caph_d = caph_q;
        fcap_d = fcap_q;
        carry_d = carry_q;
        if (pins_rise[1]) begin
            capl_d = low_q;
            fcap_d = fine_d;
            carry_d = fine_ovf;
        end
        if (pins_rise[2]) begin
            caph_d = high_q;
        end
    end

    // Capture bytes are undefined after reset, so they are left out of the reset branch
    always_ff @(posedge aclk) begin
        capl_q <= capl_d;
        caph_q <= caph_d;
        if (!aresetn) begin
            fcap_q <= fpc_pkg::RST_FINE;
            carry_q <= fpc_pkg::RST_BIT;
        end else begin
            fcap_q <= fcap_d;
            carry_q <= carry_d;
        end
    end

    // Realtime output: held frozen while armed, switches to the latch in the match cycle itself
    logic rt_active;
    assign rt_active = fc_en_q && !rt_dis_q;
    assign realtime_output_pin = (rt_active && armed_q && !fc_hit) ? frozen_q : port_latch_bit;

    // Register file
    always_comb begin
        ctrl_d = ctrl_q;
        lmatch_d = lmatch_q;
        hmatch_d = hmatch_q;
        irq01_d = irq01_q;
        irq23_d = irq23_q;
        insel_d = insel_q;
        rt_dis_d = rt_dis_q;
        fc_en_d = fc_en_q;
        cmp_d = cmp_q;
        armed_d = armed_q;
        frozen_d = frozen_q;
        if (wr_ctrl) begin
            ctrl_d = rif.wr_data;
            // Flags only clear by software; writing one keeps the present state
            ctrl_d[fpc_pkg::T0_LOW_FLAG] = rif.wr_data[fpc_pkg::T0_LOW_FLAG] & ctrl_q[fpc_pkg::T0_LOW_FLAG];
            ctrl_d[fpc_pkg::T0_HIGH_FLAG] = rif.wr_data[fpc_pkg::T0_HIGH_FLAG] & ctrl_q[fpc_pkg::T0_HIGH_FLAG];
        end
        // A hardware set wins over a clear in the same cycle
        if (low_set) begin
            ctrl_d[fpc_pkg::T0_LOW_FLAG] = 1'b1;
        end
        if (high_set) begin
            ctrl_d[fpc_pkg::T0_HIGH_FLAG] = 1'b1;
        end
        if (rif.wr_en && hit_idx(rif.wr_addr, fpc_pkg::IDX_T0_LMATCH)) begin
            lmatch_d = rif.wr_data;
        end
        if (rif.wr_en && hit_idx(rif.wr_addr, fpc_pkg::IDX_T0_HMATCH)) begin
            hmatch_d = rif.wr_data;
        end
        if (rif.wr_en && hit_idx(rif.wr_addr, fpc_pkg::IDX_IRQ01)) begin
            irq01_d = rif.wr_data;
        end
        if (rif.wr_en && hit_idx(rif.wr_addr, fpc_pkg::IDX_IRQ23)) begin
            irq23_d = rif.wr_data;
        end
        if (rif.wr_en && hit_idx(rif.wr_addr, fpc_pkg::IDX_INSEL)) begin
            insel_d = rif.wr_data;
        end
        if (rif.wr_en && hit_idx(rif.wr_addr, fpc_pkg::IDX_P1_TEST)) begin
            rt_dis_d = rif.wr_data[fpc_pkg::P1_RT_DISABLE];
        end
        if (fc_hit) begin
            armed_d = 1'b0;
        end
        if (wr_fc) begin
            fc_en_d = rif.wr_data[fpc_pkg::FC_ENABLE];
            cmp_d = rif.wr_data[fpc_pkg::FC_CMP_LSB +: 3];
            armed_d = rif.wr_data[fpc_pkg::FC_ENABLE];
            frozen_d = realtime_output_pin;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= fpc_pkg::RST_BYTE;
            lmatch_q <= fpc_pkg::RST_BYTE;
            hmatch_q <= fpc_pkg::RST_BYTE;
            irq01_q <= fpc_pkg::RST_BYTE;
            irq23_q <= fpc_pkg::RST_BYTE;
            insel_q <= fpc_pkg::RST_BYTE;
            rt_dis_q <= fpc_pkg::RST_BIT;
            fc_en_q <= fpc_pkg::RST_BIT;
            cmp_q <= fpc_pkg::RST_FINE;
            armed_q <= fpc_pkg::RST_BIT;
            frozen_q <= fpc_pkg::RST_BIT;
        end else begin
            ctrl_q <= ctrl_d;
            lmatch_q <= lmatch_d;
            hmatch_q <= hmatch_d;
            irq01_q <= irq01_d;
            irq23_q <= irq23_d;
            insel_q <= insel_d;
            rt_dis_q <= rt_dis_d;
            fc_en_q <= fc_en_d;
            cmp_q <= cmp_d;
            armed_q <= armed_d;
            frozen_q <= frozen_d;
        end
    end

    assign low_irq_req = ctrl_q[fpc_pkg::T0_LOW_FLAG] && ctrl_q[fpc_pkg::T0_LOW_IE];
    assign high_irq_req = ctrl_q[fpc_pkg::T0_HIGH_FLAG] && ctrl_q[fpc_pkg::T0_HIGH_IE];

    // Read decode; reads have no side effects
    always_comb begin
        rif.rd_data = 8'h00;
        rif.rd_ok = 1'b1;
        if (hit_idx(rif.rd_addr, fpc_pkg::IDX_T0_CTRL)) begin
            rif.rd_data = ctrl_q;
        end else if (hit_idx(rif.rd_addr, fpc_pkg::IDX_T0_LCNT)) begin
            rif.rd_data = low_q;
        end else if (hit_idx(rif.rd_addr, fpc_pkg::IDX_T0_HCNT)) begin
            rif.rd_data = high_q;
        end else if (hit_idx(rif.rd_addr, fpc_pkg::IDX_T0_LMATCH)) begin
            rif.rd_data = lmatch_q;
        end else if (hit_idx(rif.rd_addr, fpc_pkg::IDX_T0_HMATCH)) begin
            rif.rd_data = hmatch_q;
        end else if (hit_idx(rif.rd_addr, fpc_pkg::IDX_T0_CAPL)) begin
            rif.rd_data = capl_q;
        end else if (hit_idx(rif.rd_addr, fpc_pkg::IDX_T0_CAPH)) begin
            rif.rd_data = caph_q;
        end else if (hit_idx(rif.rd_addr, fpc_pkg::IDX_P1_TEST)) begin
            rif.rd_data = {5'h00, rt_dis_q, 2'h0};
        end else if (hit_idx(rif.rd_addr, fpc_pkg::IDX_IRQ01)) begin
            rif.rd_data = irq01_q;
        end else if (hit_idx(rif.rd_addr, fpc_pkg::IDX_IRQ23)) begin
            rif.rd_data = irq23_q;
        end else if (hit_idx(rif.rd_addr, fpc_pkg::IDX_INSEL)) begin
            rif.rd_data = insel_q;
        end else if (hit_idx(rif.rd_addr, fpc_pkg::IDX_FC_CTRL)) begin
            rif.rd_data = {fc_en_q, cmp_q, carry_q, fcap_q};
        end else begin
            rif.rd_ok = 1'b0;
        end
    end

    // Writes to read-only or unmapped words get an error answer and change nothing
    assign rif.wr_ok = hit_idx(rif.wr_addr, fpc_pkg::IDX_T0_CTRL) || hit_idx(rif.wr_addr, fpc_pkg::IDX_T0_LMATCH)
                    || hit_idx(rif.wr_addr, fpc_pkg::IDX_T0_HMATCH) || hit_idx(rif.wr_addr, fpc_pkg::IDX_P1_TEST)
                    || hit_idx(rif.wr_addr, fpc_pkg::IDX_IRQ01) || hit_idx(rif.wr_addr, fpc_pkg::IDX_IRQ23)
                    || hit_idx(rif.wr_addr, fpc_pkg::IDX_INSEL) || hit_idx(rif.wr_addr, fpc_pkg::IDX_FC_CTRL);
endmodule

// file: tb/fpc_ext_src.sv
// Partner model: external pulse source on the count and capture pins.
`timescale 1ns/1ps
module fpc_ext_src (
    // Clock
    input wire logic aclk,
    // Count, low capture and high capture lines
    output logic [2:0] pins
);
    initial pins = 3'h0;
    // Two cycles per phase, so the two-stage synchroniser never drops an edge
    task automatic pulse(input int n, input int k);
        repeat (n) begin
            pins[k] <= 1'b1;
            repeat (2) @(posedge aclk);
            pins[k] <= 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask
    // Count and low capture edges together, so the capture sees a fine wrap
    task automatic pulse_pair();
        pins <= 3'h3;
        repeat (2) @(posedge aclk);
        pins <= 3'h0;
        repeat (2) @(posedge aclk);
    endtask
endmodule

// file: tb/fpc_asserts.sv
// Checker for the fast pulse counter top ports.
`timescale 1ns/1ps
module fpc_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic realtime_output_pin,
    input wire logic port_latch_bit,
    input wire logic low_irq_req
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence resp_rise;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> resp_rise) else $error("late write response");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken while busy");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read data");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_rdata_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
    // A pin that differs from the latch can only be the frozen level
    a_frozen_level: assert property (realtime_output_pin != port_latch_bit |-> $stable(realtime_output_pin))
        else $error("frozen level moved");
    a_flag_clear: assert property ($fell(low_irq_req) |-> $rose(s_axi_bvalid)) else $error("flag cleared alone");
endmodule
bind fpc_top fpc_asserts chk_u (.*);

// file: tb/tb_top.sv
// Self-checking bench: register access, fine counting, match, capture and pin tests.
`timescale 1ns/1ps
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, latch = 1'b0, tick = 1'b0;
    logic [fpc_pkg::ADDR_W-1:0] awa = 18'h0, ara = 18'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic [1:0] br, rr;
    logic awr, wrd, bv, arr, rv, rt, irq, hirq;
    logic [2:0] pins;
    int err_total = 0;
    int checked = 0;
    always #4 aclk = ~aclk;
    fpc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .fast_count_input(pins[0]),
        .capture_low_pin(pins[1]), .capture_high_pin(pins[2]), .realtime_output_pin(rt), .prescale_tick(tick),
        .port_latch_bit(latch), .low_irq_req(irq), .high_irq_req(hirq));
    fpc_ext_src src_u (.aclk(aclk), .pins(pins));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] resp = fpc_pkg::RESP_OKAY);
        awa <= {idx, 2'h0};
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while ((awv && !awr) || (wv && !wrd));
        do @(posedge aclk); while (bv !== 1'b1);
        bry <= 1'b0;
        chk({30'h0, br}, {30'h0, resp});
        @(posedge aclk);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] resp = fpc_pkg::RESP_OKAY);
        ara <= {idx, 2'h0};
        arv <= 1'b1;
        rry <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge aclk); while (rv !== 1'b1);
        rry <= 1'b0;
        chk({30'h0, rr}, {30'h0, resp});
        if (resp == fpc_pkg::RESP_OKAY) chk(rdat, {24'h0, d});
        @(posedge aclk);
    endtask
    // Pulses, then one edge so the synchronised count has landed
    task automatic go(input int n, input int k);
        src_u.pulse(n, k);
        @(posedge aclk);
    endtask
    task automatic pin(input logic [1:0] e);
        chk({30'h0, rt, irq}, {30'h0, e});
    endtask
    task automatic end_of_test();
        if (err_total == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge aclk);
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(fpc_pkg::IDX_FC_CTRL, 8'h00);
        rd(16'hfe11, 8'h00, fpc_pkg::RESP_SLVERR);
        wr(fpc_pkg::IDX_T0_LMATCH, 8'h02);
        wr(fpc_pkg::IDX_T0_CTRL, 8'h51);
        latch <= 1'b1;
        go(0, 0);
        pin(2'b10);
        latch <= 1'b0;
        wr(fpc_pkg::IDX_FC_CTRL, 8'hbf);
        rd(fpc_pkg::IDX_FC_CTRL, 8'hb0);
        latch <= 1'b1;
        go(26, 0);
        pin(2'b00);
        rd(fpc_pkg::IDX_T0_LCNT, 8'h03);
        go(1, 0);
        pin(2'b11);
        rd(fpc_pkg::IDX_T0_CTRL, 8'h53);
        latch <= 1'b0;
        go(0, 0);
        pin(2'b01);
        go(1, 1);
        rd(fpc_pkg::IDX_T0_CAPL, 8'h03);
        rd(fpc_pkg::IDX_FC_CTRL, 8'hb3);
        go(1, 2);
        rd(fpc_pkg::IDX_T0_CAPH, 8'h00);
        wr(fpc_pkg::IDX_T0_CTRL, 8'h51);
        pin(2'b00);
        wr(fpc_pkg::IDX_T0_LMATCH, 8'h04);
        wr(fpc_pkg::IDX_FC_CTRL, 8'hb3);
        latch <= 1'b1;
        go(15, 0);
        pin(2'b00);
        go(1, 0);
        pin(2'b11);
        // Armed again, but the disable bit hands the pin to the latch
        wr(fpc_pkg::IDX_P1_TEST, 8'h04);
        wr(fpc_pkg::IDX_FC_CTRL, 8'hf0);
        latch <= 1'b0;
        go(0, 0);
        pin(2'b01);
        rd(fpc_pkg::IDX_P1_TEST, 8'h04);
        // Capture on the wrap edge: true count is (capture + carry) * 8 + fine
        go(4, 0);
        src_u.pulse_pair();
        go(0, 0);
        rd(fpc_pkg::IDX_T0_CAPL, 8'h05);
        rd(fpc_pkg::IDX_FC_CTRL, 8'hf8);
        rd(fpc_pkg::IDX_T0_LCNT, 8'h06);
        // 19-bit mode: one match sets both flags
        wr(fpc_pkg::IDX_T0_LMATCH, 8'h06);
        wr(fpc_pkg::IDX_T0_CTRL, 8'hf5);
        wr(fpc_pkg::IDX_FC_CTRL, 8'h90);
        go(9, 0);
        chk({31'h0, hirq}, 32'h1);
        rd(fpc_pkg::IDX_T0_CTRL, 8'hff);
        // 11-bit mode: the high byte runs on its own tick
        wr(fpc_pkg::IDX_T0_HMATCH, 8'h05);
        wr(fpc_pkg::IDX_T0_CTRL, 8'hd5);
        tick <= 1'b1;
        repeat (3) @(posedge aclk);
        tick <= 1'b0;
        @(posedge aclk);
        rd(fpc_pkg::IDX_T0_HCNT, 8'h03);
        end_of_test();
    end
endmodule
